// >>> rtl/pmcd_ctrl.sv
`timescale 1ns/100ps
`include "pmcd_regs.svh"
// Operation
// - Writing regulator frequency field 00 stops regulator, both clocks and core supply.
// - Hibernate ends only on clock wakeup or reset pin assertion.
// - Hibernate releases all output pins to high impedance.
// - Sleep gates core_clk only; PLL and sys_clk keep running.
// - Sleep wakeup goes to full-on if bypass clear, else active.
// - No DMA grant to level-one memory while asleep.
// - Deep sleep stops both clocks and blocks asynchronous peripherals.
// - Deep sleep: clock interrupt to active, reset pin to full-on.
// - Core voltage set through regulator register in 50 mV steps.
// - Regulator reactivation from power-down starts a boot sequence.
// - Multiplier 0.5x to 63.5x in half steps, 10x after reset.
// - New sys_clk divider applies at once without relock.
// - sys_clk divides the PLL output by sclk_select, 1 to 15.
// - core_clk divides by 1, 2, 4 or 8 from core_clk_select, dynamically.
// - Every peripheral runs from sys_clk, none from core_clk.
// - Active mode bypasses the PLL; both clocks run at input clock.
// - Multiplier written in active mode applies on next full-on entry.
// - After power-up start in full-on, PLL enabled, not bypassed.
module pmcd_ctrl #(
  parameter int BOOT_CYC = `PMCD_BOOT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rst_pin_n_i,
  input  wire logic        rtc_wake_i,
  input  wire logic        rtc_irq_i,
  input  wire logic        wake_i,
  input  wire logic        dma_req_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             core_clk_en_o,
  output logic             sys_clk_en_o,
  output logic             pll_en_o,
  output logic             pll_bypass_o,
  output logic [6:0]       pll_mult_o,
  output logic [3:0]       sclk_div_o,
  output logic [3:0]       core_clk_div_o,
  output logic [3:0]       vcore_level_o,
  output logic             core_supply_on_o,
  output logic             pin_oe_allow_o,
  output logic             async_block_o,
  output logic             dma_grant_o,
  output logic             boot_start_o
);
  initial
  begin
    if (BOOT_CYC < 1 || BOOT_CYC > 255)
      $error("BOOT_CYC out of range");
  end

  function automatic logic [3:0] csel_ratio(input logic [1:0] c);
    csel_ratio = 4'h1 << c;
  endfunction

  pmcd_pkg::pmcd_mode_t mode_r, mode_nxt;
  logic [7:0] vreg_r;
  logic [6:0] msel_r;
  logic [6:0] mult_r;
  logic       byp_r;
  logic       pdwn_r;
  logic [3:0] ssel_r;
  logic [1:0] csel_r;
  logic [7:0] boot_cnt_r;
  logic       ack_r;

  wire wb_req     = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr_go      = wb_req && wb_we_i && wb_sel_i[0];
  wire wr_go_hi   = wb_req && wb_we_i && wb_sel_i[1];
  wire wr_vreg    = wr_go && (wb_adr_i == `PMCD_ADR_VREG);
  wire wr_pctl    = wr_go && (wb_adr_i == `PMCD_ADR_PLLCTL);
  wire wr_pctl_hi = wr_go_hi && (wb_adr_i == `PMCD_ADR_PLLCTL);
  wire wr_div     = wr_go && (wb_adr_i == `PMCD_ADR_PLLDIV);
  wire hib_req    = wr_vreg && (wb_dat_i[`PMCD_VR_REGULATOR_FREQUENCY_FIELD_LSB +: 2] == `PMCD_REGULATOR_FREQUENCY_FIELD_OFF);
  wire sleep_req  = wr_pctl_hi && wb_dat_i[`PMCD_PC_SLEEP_BIT];
  wire deep_req   = wr_pctl_hi && wb_dat_i[`PMCD_PC_DEEP_BIT];
  wire rst_ev     = !rst_pin_n_i;
  wire [6:0] msel_wr = wb_dat_i[`PMCD_PC_MSEL_LSB +: 7];
  wire        msel_ok = (msel_wr >= `PMCD_MSEL_MIN);
  wire [3:0]  ssel_wr = wb_dat_i[3:0];
  wire        is_full = (mode_r == pmcd_pkg::PMCD_FULL);
  wire        is_act  = (mode_r == pmcd_pkg::PMCD_ACT);
  wire        running = is_full || is_act;
  wire        wake_hib = rtc_wake_i || rst_ev;
  wire        boot_ev  = (mode_r == pmcd_pkg::PMCD_HIB) && wake_hib;

  // Mode machine; software requests only while running, wake events by mode.
  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      pmcd_pkg::PMCD_FULL, pmcd_pkg::PMCD_ACT:
      begin
        if (hib_req)
          mode_nxt = pmcd_pkg::PMCD_HIB;
        else if (deep_req)
          mode_nxt = pmcd_pkg::PMCD_DEEP;
        else if (sleep_req)
          mode_nxt = pmcd_pkg::PMCD_SLEEP;
        else if (wr_pctl_hi)
          mode_nxt = wb_dat_i[`PMCD_PC_BYP_BIT] ? pmcd_pkg::PMCD_ACT : pmcd_pkg::PMCD_FULL;
      end
      pmcd_pkg::PMCD_SLEEP:
      begin
        if (rst_ev)
          mode_nxt = pmcd_pkg::PMCD_FULL;
        else if (wake_i || rtc_irq_i)
          mode_nxt = byp_r ? pmcd_pkg::PMCD_ACT : pmcd_pkg::PMCD_FULL;
      end
      pmcd_pkg::PMCD_DEEP:
      begin
        if (rst_ev)
          mode_nxt = pmcd_pkg::PMCD_FULL;
        else if (rtc_irq_i)
          mode_nxt = pmcd_pkg::PMCD_ACT;
      end
      pmcd_pkg::PMCD_HIB:
      begin
        if (wake_hib)
          mode_nxt = pmcd_pkg::PMCD_FULL;
      end
      default: mode_nxt = pmcd_pkg::PMCD_FULL;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= pmcd_pkg::PMCD_FULL;
      vreg_r <= `PMCD_VR_RST;
      msel_r <= `PMCD_MSEL_RST;
      mult_r <= `PMCD_MSEL_RST;
      byp_r  <= 1'b0;
      pdwn_r <= 1'b0;
      ssel_r <= `PMCD_SSEL_RST;
      csel_r <= `PMCD_CSEL_RST;
      ack_r  <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      ack_r  <= wb_req;
      if (wr_vreg)
        vreg_r <= wb_dat_i[7:0];
      if (wr_pctl && msel_ok)
        msel_r <= msel_wr;
      if (wr_pctl_hi && running)
      begin
        byp_r  <= wb_dat_i[`PMCD_PC_BYP_BIT];
        pdwn_r <= wb_dat_i[`PMCD_PC_PDWN_BIT] && wb_dat_i[`PMCD_PC_BYP_BIT];
      end
      // The multiplier only reaches the PLL on entering or staying in full-on.
      if (mode_nxt == pmcd_pkg::PMCD_FULL)
        mult_r <= (wr_pctl && msel_ok) ? msel_wr : msel_r;
      if (wr_div && ssel_wr != 4'h0)
        ssel_r <= ssel_wr;
      if (wr_div)
        csel_r <= wb_dat_i[`PMCD_DV_CSEL_LSB +: 2];
    end
  end

  // Boot pulse counter; a pulse longer than one cycle lets slow boot logic see it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      boot_cnt_r <= 8'h00;
    else if (boot_ev)
      boot_cnt_r <= 8'(BOOT_CYC);
    else if (boot_cnt_r != 8'h00)
      boot_cnt_r <= boot_cnt_r - 8'h01;
  end

  wire [31:0] rd_mux =
    (wb_adr_i == `PMCD_ADR_VREG)   ? {24'h000000, vreg_r} :
    (wb_adr_i == `PMCD_ADR_PLLCTL) ? {22'h000000, pdwn_r, byp_r, 1'b0, msel_r} :
    (wb_adr_i == `PMCD_ADR_PLLDIV) ? {26'h0000000, csel_r, ssel_r} :
    (wb_adr_i == `PMCD_ADR_MODE)   ? {29'h00000000, mode_r} : 32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else if (wb_req && !wb_we_i)
      wb_dat_o <= rd_mux;
  end

  assign wb_ack_o         = ack_r;
  assign core_clk_en_o    = running;
  assign sys_clk_en_o     = running || (mode_r == pmcd_pkg::PMCD_SLEEP);
  assign pll_en_o         = is_full || (mode_r == pmcd_pkg::PMCD_SLEEP) || (is_act && !pdwn_r);
  assign pll_bypass_o     = is_act;
  assign pll_mult_o       = mult_r;
  assign sclk_div_o       = is_act ? 4'h1 : ssel_r;
  assign core_clk_div_o       = is_act ? 4'h1 : csel_ratio(csel_r);
  assign vcore_level_o    = vreg_r[`PMCD_VR_VLEV_LSB +: 4];
  assign core_supply_on_o = (mode_r != pmcd_pkg::PMCD_HIB);
  assign pin_oe_allow_o   = (mode_r != pmcd_pkg::PMCD_HIB);
  assign async_block_o    = (mode_r == pmcd_pkg::PMCD_DEEP) || (mode_r == pmcd_pkg::PMCD_HIB);
  assign dma_grant_o      = dma_req_i && running;
  assign boot_start_o     = (boot_cnt_r != 8'h00);

  a_hib_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    running && hib_req |=> !core_supply_on_o && !core_clk_en_o && !sys_clk_en_o)
    else $error("hibernate entry failed");
  a_hib_stay: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r == pmcd_pkg::PMCD_HIB && !rtc_wake_i && rst_pin_n_i |=> mode_r == pmcd_pkg::PMCD_HIB)
    else $error("hibernate left without cause");
  a_hib_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r == pmcd_pkg::PMCD_HIB |-> !pin_oe_allow_o)
    else $error("pins driven in hibernate");
  a_sleep_clk: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r == pmcd_pkg::PMCD_SLEEP |-> !core_clk_en_o && sys_clk_en_o && pll_en_o)
    else $error("sleep clocks wrong");
  sequence s_sleep_wake;
    mode_r == pmcd_pkg::PMCD_SLEEP && wake_i && rst_pin_n_i;
  endsequence
  a_sleep_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sleep_wake ##1 1'b1 |-> mode_r == ($past(byp_r) ? pmcd_pkg::PMCD_ACT : pmcd_pkg::PMCD_FULL))
    else $error("sleep wake target wrong");
  a_sleep_dma: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r == pmcd_pkg::PMCD_SLEEP |-> !dma_grant_o)
    else $error("dma granted in sleep");
  a_deep_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r == pmcd_pkg::PMCD_DEEP && rst_pin_n_i && rtc_irq_i |=> is_act)
    else $error("deep sleep exit wrong");
  sequence s_hib_wake;
    mode_r == pmcd_pkg::PMCD_HIB && rtc_wake_i;
  endsequence
  a_boot_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_hib_wake |=> boot_start_o [*1] ##0 is_full)
    else $error("no boot after wake");
  a_div_now: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_div && is_full && ssel_wr != 4'h0 |=> sclk_div_o == $past(ssel_wr))
    else $error("sys divider not immediate");
  a_act_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
    is_act |-> pll_bypass_o && sclk_div_o == 4'h1 && core_clk_div_o == 4'h1)
    else $error("active clocks wrong");
  a_mult_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    is_act && $past(is_act) |-> $stable(pll_mult_o))
    else $error("multiplier changed in active");

  // Mode level checks: each mode must show its own clock and supply pattern.
  // These catch a wrong decode even when no scenario walks the exact path.
  a_deep_clk: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r == pmcd_pkg::PMCD_DEEP |-> !core_clk_en_o && !sys_clk_en_o && async_block_o && !pll_en_o)
    else $error("deep sleep clocks wrong");
  a_deep_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r == pmcd_pkg::PMCD_DEEP && !rst_pin_n_i |=> is_full)
    else $error("deep sleep pin exit wrong");
  a_hib_supply: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r == pmcd_pkg::PMCD_HIB |-> !core_supply_on_o && !core_clk_en_o && !sys_clk_en_o)
    else $error("hibernate supply on");
  a_run_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r != pmcd_pkg::PMCD_HIB |-> pin_oe_allow_o)
    else $error("pins released outside hibernate");
  a_full_pll: assert property (@(posedge clk_i) disable iff (rst_i)
    is_full |-> pll_en_o && !pll_bypass_o && core_clk_en_o && sys_clk_en_o)
    else $error("full-on clocks wrong");
  a_act_clk: assert property (@(posedge clk_i) disable iff (rst_i)
    is_act |-> core_clk_en_o && sys_clk_en_o && core_supply_on_o)
    else $error("active clocks stopped");
  a_act_dma: assert property (@(posedge clk_i) disable iff (rst_i)
    running && dma_req_i |-> dma_grant_o)
    else $error("dma refused while running");

  // Register and divider checks; a zero divider would stall every peripheral.
  a_vcore_field: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_vreg |=> vcore_level_o == $past(wb_dat_i[`PMCD_VR_VLEV_LSB +: 4]))
    else $error("voltage level not taken");
  a_sclk_nonzero: assert property (@(posedge clk_i) disable iff (rst_i)
    sclk_div_o != 4'h0)
    else $error("sys divider zero");
  a_core_clk_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
    core_clk_div_o == 4'h1 || core_clk_div_o == 4'h2 || core_clk_div_o == 4'h4 || core_clk_div_o == 4'h8)
    else $error("core divider illegal");
  a_periph_clk: assert property (@(posedge clk_i) disable iff (rst_i)
    core_clk_en_o |-> sys_clk_en_o)
    else $error("core clock without sys clock");
  a_mult_range: assert property (@(posedge clk_i) disable iff (rst_i)
    pll_mult_o >= `PMCD_MSEL_MIN)
    else $error("multiplier below minimum");

  // The mode only moves on a request or a wake event, never on its own.
  a_mode_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    is_full || is_act || mode_r == pmcd_pkg::PMCD_SLEEP || mode_r == pmcd_pkg::PMCD_DEEP
    || mode_r == pmcd_pkg::PMCD_HIB)
    else $error("mode code illegal");
  a_mode_still: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_req && !rst_ev && !rtc_wake_i && !rtc_irq_i && !wake_i |=> $stable(mode_r))
    else $error("mode moved without event");
endmodule // pmcd_ctrl

// >>> rtl/pmcd_pkg.sv
package pmcd_pkg;
  typedef enum logic [2:0] {
    PMCD_FULL  = 3'h0,
    PMCD_ACT   = 3'h1,
    PMCD_SLEEP = 3'h3,
    PMCD_DEEP  = 3'h2,
    PMCD_HIB   = 3'h6
  } pmcd_mode_t;
endpackage

// >>> rtl/pmcd_regs.svh
`ifndef PMCD_REGS_SVH
`define PMCD_REGS_SVH
// Register byte addresses.
`define PMCD_ADR_VREG     4'h0
`define PMCD_ADR_PLLCTL   4'h4
`define PMCD_ADR_PLLDIV   4'h8
`define PMCD_ADR_MODE     4'hC
// Regulator control fields.
`define PMCD_VR_REGULATOR_FREQUENCY_FIELD_LSB  0
`define PMCD_VR_VLEV_LSB  4
`define PMCD_VR_RST       8'h3B
`define PMCD_REGULATOR_FREQUENCY_FIELD_OFF     2'h0
// PLL control fields; multiplier in half steps, 20 means 10x.
`define PMCD_PC_MSEL_LSB  0
`define PMCD_PC_BYP_BIT   8
`define PMCD_PC_PDWN_BIT  9
`define PMCD_PC_SLEEP_BIT 10
`define PMCD_PC_DEEP_BIT  11
`define PMCD_MSEL_RST     7'h14
`define PMCD_MSEL_MIN     7'h01
`define PMCD_MSEL_MAX     7'h7F
// Divider fields.
`define PMCD_DV_CSEL_LSB  4
`define PMCD_SSEL_RST     4'h5
`define PMCD_CSEL_RST     2'h0
// Boot pulse length, 1 us at 100 ns.
`define PMCD_BOOT_NS      1000
`define PMCD_CLK_NS       100
`define PMCD_BOOT_CYC     ((`PMCD_BOOT_NS + `PMCD_CLK_NS - 1) / `PMCD_CLK_NS)
`endif

// >>> tb/pmcd_tb.sv
`timescale 1ns/100ps
`include "pmcd_regs.svh"
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, a); end end
module tb;
  localparam int BOOT = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        rst_pin_n_i = 1'b1;
  logic        rtc_wake_i = 1'b0;
  logic        rtc_irq_i = 1'b0;
  logic        wake_i = 1'b0;
  logic        dma_req_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, core_clk_en_o, sys_clk_en_o, pll_en_o, pll_bypass_o;
  logic [6:0]  pll_mult_o;
  logic [3:0]  sclk_div_o, core_clk_div_o, vcore_level_o, s;
  logic        core_supply_on_o, pin_oe_allow_o, async_block_o, dma_grant_o, boot_start_o;
  int          err_count = 0;
  int          checked = 0;
  int          n;
  pmcd_ctrl #(.BOOT_CYC(BOOT)) u_pmcd_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .rst_pin_n_i(rst_pin_n_i), .rtc_wake_i(rtc_wake_i), .rtc_irq_i(rtc_irq_i), .wake_i(wake_i),
    .dma_req_i(dma_req_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .core_clk_en_o(core_clk_en_o), .sys_clk_en_o(sys_clk_en_o),
    .pll_en_o(pll_en_o), .pll_bypass_o(pll_bypass_o), .pll_mult_o(pll_mult_o),
    .sclk_div_o(sclk_div_o), .core_clk_div_o(core_clk_div_o), .vcore_level_o(vcore_level_o),
    .core_supply_on_o(core_supply_on_o), .pin_oe_allow_o(pin_oe_allow_o),
    .async_block_o(async_block_o), .dma_grant_o(dma_grant_o), .boot_start_o(boot_start_o));
  always #50 clk_i = ~clk_i;
  function automatic logic [31:0] pc(input logic [6:0] m, input logic b, sl, dp);
    return {20'h0, dp, sl, 1'b0, b, 1'b0, m};
  endfunction
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a;
    wb_sel_i <= 4'hF; wb_dat_i <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) err_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  // Pulse one event input for a single cycle, then let the mode settle.
  task automatic pulse(input int w);
    @(posedge clk_i);
    case (w)
      0: wake_i <= 1'b1;
      1: rtc_irq_i <= 1'b1;
      default: rst_pin_n_i <= 1'b0;
    endcase
    @(posedge clk_i);
    wake_i <= 1'b0;
    rtc_irq_i <= 1'b0;
    rst_pin_n_i <= 1'b1;
    tick(3);
  endtask
  task automatic mode(input string nm, input pmcd_pkg::pmcd_mode_t m);
    wb(1'b0, `PMCD_ADR_MODE, 32'h0);
    `CHK(nm, m, rd[2:0])
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    err_count++;
    test_done;
  end
  initial begin
    n = $urandom(7);
    tick(20); rst_i <= 1'b0; tick(1);
    mode("reset mode", pmcd_pkg::PMCD_FULL);
    `CHK("reset pll", 3'b101, {pll_en_o, pll_bypass_o, core_clk_en_o})
    `CHK("reset mult", 7'h14, pll_mult_o)
    wb(1'b0, `PMCD_ADR_VREG, 32'h0); `CHK("vreg reset", 8'h3B, rd[7:0])
    wb(1'b0, 4'h2, 32'h0); `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 4'hF : 4'($urandom_range(15, 1));
      wb(1'b1, `PMCD_ADR_PLLDIV, {26'h0, 2'(i % 4), s}); tick(1);
      `CHK("sclk div", s, sclk_div_o)
      `CHK("core_clk div", 4'h1 << (i % 4), core_clk_div_o)
    end
    wb(1'b1, `PMCD_ADR_PLLDIV, 32'h0); tick(1);
    `CHK("sclk zero", s, sclk_div_o)
    wb(1'b1, `PMCD_ADR_VREG, 32'h51); tick(1);
    `CHK("vcore", 4'h5, vcore_level_o)
    $display("test dividers done");
    wb(1'b1, `PMCD_ADR_PLLCTL, pc(7'h1E, 1, 0, 0)); tick(2);
    mode("active", pmcd_pkg::PMCD_ACT);
    `CHK("act divs", 9'h111, {pll_bypass_o, sclk_div_o, core_clk_div_o})
    `CHK("act mult", 7'h14, pll_mult_o)
    wb(1'b1, `PMCD_ADR_PLLCTL, pc(7'h1E, 1, 1, 0)); tick(2);
    mode("sleep byp", pmcd_pkg::PMCD_SLEEP);
    pulse(0);
    mode("wake active", pmcd_pkg::PMCD_ACT);
    wb(1'b1, `PMCD_ADR_PLLCTL, pc(7'h1E, 0, 0, 0)); tick(2);
    mode("full", pmcd_pkg::PMCD_FULL);
    `CHK("full mult", 7'h1E, pll_mult_o)
    `CHK("full grant", 1'b1, dma_grant_o)
    wb(1'b1, `PMCD_ADR_PLLCTL, pc(7'h1E, 0, 1, 0)); tick(2);
    mode("sleep", pmcd_pkg::PMCD_SLEEP);
    `CHK("sleep clks", 3'b011, {core_clk_en_o, sys_clk_en_o, pll_en_o})
    `CHK("sleep grant", 1'b0, dma_grant_o)
    pulse(1);
    mode("wake full", pmcd_pkg::PMCD_FULL);
    $display("test sleep done");
    wb(1'b1, `PMCD_ADR_PLLCTL, pc(7'h1E, 0, 0, 1)); tick(2);
    mode("deep", pmcd_pkg::PMCD_DEEP);
    `CHK("deep clks", 3'b001, {core_clk_en_o, sys_clk_en_o, async_block_o})
    pulse(0);
    mode("deep hold", pmcd_pkg::PMCD_DEEP);
    pulse(1);
    mode("deep irq", pmcd_pkg::PMCD_ACT);
    wb(1'b1, `PMCD_ADR_PLLCTL, pc(7'h1E, 1, 0, 1)); tick(2);
    pulse(2);
    mode("deep pin", pmcd_pkg::PMCD_FULL);
    $display("test deep done");
    wb(1'b1, `PMCD_ADR_VREG, {24'h0, 4'h5, 2'h0, `PMCD_REGULATOR_FREQUENCY_FIELD_OFF}); tick(2);
    mode("hib", pmcd_pkg::PMCD_HIB);
    `CHK("hib outs", 4'h0, {core_clk_en_o, sys_clk_en_o, core_supply_on_o, pin_oe_allow_o})
    pulse(1);
    pulse(0);
    mode("hib hold", pmcd_pkg::PMCD_HIB);
    @(posedge clk_i); rtc_wake_i <= 1'b1;
    @(posedge clk_i); rtc_wake_i <= 1'b0;
    #1;
    n = (boot_start_o === 1'b1) ? 1 : 0;
    repeat (30) begin @(posedge clk_i); #1; if (boot_start_o === 1'b1) n++; end
    `CHK("boot len", BOOT, n)
    mode("hib wake", pmcd_pkg::PMCD_FULL);
    `CHK("hib supply", 2'b11, {core_supply_on_o, pin_oe_allow_o})
    $display("test hibernate done");
    test_done;
  end
endmodule // tb
